// *** design/psc_startup.sv ***
// The address map and the AHB-Lite register port were chosen for this implementation.
module psc_startup (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic reconfigure_request_n,
  input wire logic error_status_n_in,
  output logic error_status_n_out,
  output logic error_status_n_oe,
  input wire logic load_complete_in,
  output logic load_complete_out,
  output logic load_complete_oe,
  input wire logic user_startup_clock,
  input wire logic serial_cfg_clock,
  input wire logic serial_cfg_data,
  input wire logic chain_enable_in_n,
  output logic chain_enable_out_n,
  output logic init_done_out,
  output logic init_done_oe,
  output logic user_io_hiz,
  output logic [7:0] cfg_byte,
  output logic cfg_byte_valid
);
`include "psc_params.svh"

  // ========================================================================
  // pin synchronisers
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_m;
  logic [NPIN-1:0] pin_s;
  psc_pkg::psc_pins_type pins;
  logic uclk_d;
  logic sclk_d;

  assign pin_raw = {reconfigure_request_n, error_status_n_in, load_complete_in,
    user_startup_clock, serial_cfg_clock, serial_cfg_data, chain_enable_in_n};
  assign pins = psc_pkg::psc_pins_type'(pin_s);

  // two flops per pin; the first is read only by the second
  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_m[i] <= 1'b0;
          pin_s[i] <= 1'b0;
        end else if (ce) begin
          pin_m[i] <= pin_raw[i];
          pin_s[i] <= pin_m[i];
        end
      end
    end
  endgenerate

  // edge history for the two sampled clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uclk_d <= 1'b0;
      sclk_d <= 1'b0;
    end else if (ce) begin
      uclk_d <= pins.uclk;
      sclk_d <= pins.sclk;
    end
  end

  // ========================================================================
  // register file state
  logic [4:0] ctrl;
  logic [31:0] load_len;
  logic err_sticky;
  logic wr_pend;
  logic [31:0] wr_addr;

  // ========================================================================
  // sequencer signals
  psc_pkg::psc_state_type st;
  psc_pkg::psc_state_type next_st;
  logic [31:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_byte;
  logic take_bit;
  logic sync_bad;
  logic load_end;
  logic chain_err;
  logic [1:0] guard;
  logic [3:0] osc_div;
  logic [8:0] tick_cnt;
  logic [8:0] uclk_cnt;
  logic [11:0] rst_tmr;
  logic init_end;
  logic drive_init_low;

  // a clock edge is only taken while loading and selected by the chain
  assign take_bit = (st == psc_pkg::st_config) && !pins.cein_n
    && pins.sclk && !sclk_d;
  assign next_byte = {pins.sdata, shreg[7:1]};
  assign sync_bad = take_bit && (bit_cnt == 32'd7) && (next_byte != `PSC_SYNC_BYTE);
  assign load_end = take_bit && (bit_cnt == load_len - 32'd1);
  // another device on the shared line pulled it low; guard hides sync lag
  assign chain_err = (guard == `PSC_GUARD_CYC) && !pins.err_n;
  // init waits for the wired load-complete line so a chain starts together
  assign init_end = pins.ld_done && (ctrl[`PSC_CTRL_UCLK]
    ? (uclk_cnt == 9'(`PSC_UCLK_CYCLES))
    : (tick_cnt == 9'(`PSC_INIT_TICKS)));

  // ========================================================================
  // next state
  always_comb begin
    next_st = st;
    unique case (st)
      psc_pkg::st_reset: begin
        if (pins.rcfg_n) next_st = psc_pkg::st_config;
      end
      psc_pkg::st_config: begin
        if (sync_bad || chain_err) next_st = psc_pkg::st_error;
        else if (load_end) next_st = psc_pkg::st_init;
      end
      psc_pkg::st_init: begin
        if (chain_err) next_st = psc_pkg::st_error;
        else if (init_end) next_st = psc_pkg::st_user;
      end
      psc_pkg::st_user: begin
        next_st = psc_pkg::st_user;
      end
      psc_pkg::st_error: begin
        if (ctrl[`PSC_CTRL_AUTORST] && rst_tmr == 12'(`PSC_RESTART_CYC - 1)) begin
          next_st = psc_pkg::st_config;
        end
      end
      default: next_st = psc_pkg::st_reset;
    endcase
    if (!pins.rcfg_n) next_st = psc_pkg::st_reset;
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= psc_pkg::st_reset;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ========================================================================
  // serial loader: lsb first, one byte out per eight bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_cnt <= 32'h0000_0000;
      shreg <= 8'h00;
      cfg_byte <= 8'h00;
      cfg_byte_valid <= 1'b0;
    end else if (ce) begin
      cfg_byte_valid <= 1'b0;
      if (st != psc_pkg::st_config) begin
        bit_cnt <= 32'h0000_0000;
      end else if (take_bit) begin
        bit_cnt <= bit_cnt + 32'd1;
        shreg <= next_byte;
        if (bit_cnt[2:0] == 3'h7) begin
          cfg_byte <= next_byte;
          cfg_byte_valid <= 1'b1;
        end
      end
    end
  end

  // shared-line guard restarts whenever this device itself drives low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      guard <= 2'h0;
    end else if (ce) begin
      if (st == psc_pkg::st_reset || st == psc_pkg::st_error) guard <= 2'h0;
      else if (guard != `PSC_GUARD_CYC) guard <= guard + 2'h1;
    end
  end

  // ========================================================================
  // initialization timing: internal tick or user clock edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_div <= 4'h0;
      tick_cnt <= 9'h000;
      uclk_cnt <= 9'h000;
    end else if (ce) begin
      if (st != psc_pkg::st_init || !pins.ld_done) begin
        osc_div <= 4'h0;
        tick_cnt <= 9'h000;
        uclk_cnt <= 9'h000;
      end else begin
        osc_div <= (osc_div == 4'(`PSC_OSC_DIV - 1)) ? 4'h0 : osc_div + 4'h1;
        if (osc_div == 4'(`PSC_OSC_DIV - 1) && !init_end) begin
          tick_cnt <= tick_cnt + 9'h001;
        end
        // edges may stop for ever: the host chooses when to finish
        if (pins.uclk && !uclk_d && !init_end) uclk_cnt <= uclk_cnt + 9'h001;
      end
    end
  end

  // error timeout before auto-restart releases the status line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_tmr <= 12'h000;
    end else if (ce) begin
      if (st != psc_pkg::st_error) rst_tmr <= 12'h000;
      else if (rst_tmr != 12'(`PSC_RESTART_CYC - 1)) rst_tmr <= rst_tmr + 12'h001;
    end
  end

  // init-done is armed by the first frame when the option is on; an error
  // drops it so that an auto-restart starts clean with a new first frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_init_low <= 1'b0;
    end else if (ce) begin
      if (next_st == psc_pkg::st_reset || next_st == psc_pkg::st_user
        || next_st == psc_pkg::st_error) begin
        drive_init_low <= 1'b0;
      end else if (take_bit && bit_cnt == 32'd7 && ctrl[`PSC_CTRL_INITEN]) begin
        drive_init_low <= 1'b1;
      end
    end
  end

  // ========================================================================
  // pin drivers, registered from the next state so they align with st
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      error_status_n_out <= 1'b0;
      error_status_n_oe <= 1'b1;
      load_complete_out <= 1'b0;
      load_complete_oe <= 1'b1;
      init_done_out <= 1'b0;
      init_done_oe <= 1'b0;
      user_io_hiz <= 1'b1;
      chain_enable_out_n <= 1'b1;
    end else if (ce) begin
      error_status_n_out <= 1'b0;
      load_complete_out <= 1'b0;
      init_done_out <= 1'b0;
      error_status_n_oe <= (next_st == psc_pkg::st_reset) || (next_st == psc_pkg::st_error);
      load_complete_oe <= (next_st != psc_pkg::st_init) && (next_st != psc_pkg::st_user);
      user_io_hiz <= (next_st != psc_pkg::st_user);
      init_done_oe <= (next_st != psc_pkg::st_reset) && (next_st != psc_pkg::st_user)
        && (next_st != psc_pkg::st_error)
        && ((take_bit && bit_cnt == 32'd7 && ctrl[`PSC_CTRL_INITEN]) || drive_init_low);
      if (next_st == psc_pkg::st_user && ctrl[`PSC_CTRL_CEO_USER]) begin
        chain_enable_out_n <= ctrl[`PSC_CTRL_CEO_VAL];
      end else begin
        chain_enable_out_n <= !(next_st == psc_pkg::st_init || next_st == psc_pkg::st_user);
      end
    end
  end

  // ========================================================================
  // AHB-Lite slave: zero wait states, always OKAY
  function automatic logic [3:0] reg_sel(input logic [31:0] a);
    reg_sel = {a == `PSC_ADDR_COUNT, a == `PSC_ADDR_STATUS,
      a == `PSC_ADDR_LEN, a == `PSC_ADDR_CTRL};
  endfunction

  // address phase capture for the write that follows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        wr_pend <= hsel && htrans[1] && hwrite;
        wr_addr <= haddr;
      end
    end
  end

  // read data is prepared in the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= 32'h0000_0000;
      unique case (reg_sel(haddr))
        4'b0001: hrdata <= {27'h0, ctrl};
        4'b0010: hrdata <= load_len;
        4'b0100: hrdata <= {23'h0, err_sticky, 3'h0, st};
        4'b1000: hrdata <= bit_cnt;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // control words; status error bit is write-one-to-clear, a new error wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `PSC_CTRL_RST;
      load_len <= `PSC_LEN_RST;
      err_sticky <= 1'b0;
    end else if (ce) begin
      if (wr_pend && reg_sel(wr_addr) == 4'b0001) ctrl <= hwdata[4:0];
      if (wr_pend && reg_sel(wr_addr) == 4'b0010) load_len <= hwdata;
      if (next_st == psc_pkg::st_error && st != psc_pkg::st_error) err_sticky <= 1'b1;
      else if (wr_pend && reg_sel(wr_addr) == 4'b0100 && hwdata[`PSC_STAT_ERR]) begin
        err_sticky <= 1'b0;
      end
    end
  end

  // ========================================================================
  // checks
  property p_rcfg_reset;
    @(posedge hclk) disable iff (!hresetn)
      ce && !pins.rcfg_n |=> st == psc_pkg::st_reset && error_status_n_oe
      && load_complete_oe && user_io_hiz;
  endproperty
  a_rcfg_reset: assert property (p_rcfg_reset) else $error("reconfigure did not reset");

  property p_load_chain;
    @(posedge hclk) disable iff (!hresetn)
      ce && load_end && !sync_bad && pins.rcfg_n && !chain_err |=> st == psc_pkg::st_init
      && !chain_enable_out_n && !load_complete_oe;
  endproperty
  a_load_chain: assert property (p_load_chain) else $error("chain enable not passed on");

  property p_uclk_count;
    @(posedge hclk) disable iff (!hresetn)
      $rose(st == psc_pkg::st_user) && ctrl[`PSC_CTRL_UCLK] |-> $past(uclk_cnt) == 9'd299;
  endproperty
  a_uclk_count: assert property (p_uclk_count) else $error("user mode before 299 edges");

  property p_osc_time;
    @(posedge hclk) disable iff (!hresetn)
      $rose(st == psc_pkg::st_user) && !ctrl[`PSC_CTRL_UCLK] |-> $past(tick_cnt) == 9'd200;
  endproperty
  a_osc_time: assert property (p_osc_time) else $error("init time off");

  property p_restart;
    @(posedge hclk) disable iff (!hresetn)
      ce && st == psc_pkg::st_error && pins.rcfg_n && ctrl[`PSC_CTRL_AUTORST]
      && rst_tmr == 12'd3999 |=> st == psc_pkg::st_config && !error_status_n_oe;
  endproperty
  a_restart: assert property (p_restart) else $error("auto-restart late");

  property p_error_drive;
    @(posedge hclk) disable iff (!hresetn)
      ce && sync_bad && pins.rcfg_n |=> st == psc_pkg::st_error && error_status_n_oe
      && err_sticky;
  endproperty
  a_error_drive: assert property (p_error_drive) else $error("error not reported");

  property p_init_done_off;
    @(posedge hclk) disable iff (!hresetn)
      st == psc_pkg::st_user || (st == psc_pkg::st_config && bit_cnt < 32'd8) |-> !init_done_oe;
  endproperty
  a_init_done_off: assert property (p_init_done_off) else $error("init-done driven early");

  property p_init_done_low;
    @(posedge hclk) disable iff (!hresetn)
      st == psc_pkg::st_init && ctrl[`PSC_CTRL_INITEN] && $stable(ctrl) |-> init_done_oe;
  endproperty
  a_init_done_low: assert property (p_init_done_low) else $error("init-done not low");

  property p_ignore_sclk;
    @(posedge hclk) disable iff (!hresetn)
      st != psc_pkg::st_config |-> !take_bit ##1 !cfg_byte_valid;
  endproperty
  a_ignore_sclk: assert property (p_ignore_sclk) else $error("serial clock taken");
endmodule

// *** shared/psc_params.svh ***
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH
// ==========================================================================
// clock and timing
`define PSC_CLK_MHZ 100
`define PSC_OSC_MHZ 10
`define PSC_OSC_DIV (`PSC_CLK_MHZ / `PSC_OSC_MHZ)
`define PSC_INIT_US 20
`define PSC_INIT_TICKS (`PSC_INIT_US * `PSC_OSC_MHZ)
`define PSC_UCLK_CYCLES 299
`define PSC_RESTART_US 40
`define PSC_RESTART_CYC (`PSC_RESTART_US * `PSC_CLK_MHZ)
`define PSC_GUARD_CYC 2'h3
// ==========================================================================
// bitstream
`define PSC_SYNC_BYTE 8'h6A
`define PSC_LEN_RST 32'h0000_0100
// ==========================================================================
// register map
`define PSC_ADDR_CTRL 32'h0000_0000
`define PSC_ADDR_LEN 32'h0000_0004
`define PSC_ADDR_STATUS 32'h0000_0008
`define PSC_ADDR_COUNT 32'h0000_000C
`define PSC_CTRL_RST 5'h00
`define PSC_CTRL_UCLK 0
`define PSC_CTRL_INITEN 1
`define PSC_CTRL_AUTORST 2
`define PSC_CTRL_CEO_USER 3
`define PSC_CTRL_CEO_VAL 4
`define PSC_STAT_ERR 8
`endif

// *** shared/psc_pkg.sv ***
package psc_pkg;
  // ========================================================================
  // startup sequencer states
  typedef enum logic [4:0] {
    st_reset = 5'b00001,
    st_config = 5'b00010,
    st_init = 5'b00100,
    st_user = 5'b01000,
    st_error = 5'b10000
  } psc_state_type;
  // ========================================================================
  // configuration pins after synchronisation
  typedef struct packed {
    logic rcfg_n;
    logic err_n;
    logic ld_done;
    logic uclk;
    logic sclk;
    logic sdata;
    logic cein_n;
  } psc_pins_type;
endpackage

// *** test/psc_host.sv ***
module psc_host (
  input wire logic err_line,
  output logic reconfigure_request_n,
  output logic serial_cfg_clock,
  output logic serial_cfg_data,
  output logic user_startup_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // host side of the link: lines start idle, link clock stands low
  initial begin
    reconfigure_request_n = 1'b1;
    serial_cfg_clock = 1'b0;
    serial_cfg_data = 1'b0;
    user_startup_clock = 1'b0;
  end
  // request pulse; callers keep it at 2 us or longer
  task automatic pulse_rcfg(input int len_ns);
    reconfigure_request_n = 1'b0;
    #(len_ns);
    reconfigure_request_n = 1'b1;
  endtask
  // no data before the status line is released
  task automatic wait_ready(output bit ok);
    ok = 1'b0;
    for (int n = 0; n < 1000 && !ok; n++) begin
      #10;
      ok = (err_line === 1'b1);
    end
  endtask
  // one byte lsb first at 8 MHz, then park data at the inverse of bit 7
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      serial_cfg_data = b[i];
      #62.5 serial_cfg_clock = 1'b1;
      #62.5 serial_cfg_clock = 1'b0;
    end
    serial_cfg_data = ~b[7];
  endtask
  // 25 MHz so that the two-flop sampler catches every edge
  task automatic user_clocks(input int n);
    repeat (n) begin
      #20 user_startup_clock = 1'b1;
      #20 user_startup_clock = 1'b0;
    end
  endtask
endmodule

// *** test/psc_startup_bench.sv ***
`include "psc_params.svh"
module psc_startup_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cein_n, other_pull, mon_on, ce_on;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic rcfg_n, sclk, sdata, uclk, err_oe, err_out, ld_oe, ld_out, err_wire, ld_wire;
  logic ceo_n, idone_out, idone_oe, hiz, byte_vld, idone_wire;
  logic [7:0] cfg_byte;
  logic [7:0] exp_q[$];
  int error_cnt, total_checks;
  time t0;
  bit ok;
  // ==========================================================================
  // wired lines with pull-ups; the host never pulls load-complete
  assign err_wire = ((err_oe && !err_out) || other_pull) ? 1'b0 : 1'b1;
  assign ld_wire = (ld_oe && !ld_out) ? 1'b0 : 1'b1;
  // init-done line as the host sees it, open drain with pull-up
  assign idone_wire = (idone_oe && !idone_out) ? 1'b0 : 1'b1;
  psc_startup dut (.hclk(hclk), .hresetn(hresetn), .ce(ce_on), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reconfigure_request_n(rcfg_n),
    .error_status_n_in(err_wire), .error_status_n_out(err_out), .error_status_n_oe(err_oe),
    .load_complete_in(ld_wire), .load_complete_out(ld_out), .load_complete_oe(ld_oe),
    .user_startup_clock(uclk), .serial_cfg_clock(sclk), .serial_cfg_data(sdata),
    .chain_enable_in_n(cein_n), .chain_enable_out_n(ceo_n), .init_done_out(idone_out),
    .init_done_oe(idone_oe), .user_io_hiz(hiz), .cfg_byte(cfg_byte), .cfg_byte_valid(byte_vld));
  psc_host host (.err_line(err_wire), .reconfigure_request_n(rcfg_n),
    .serial_cfg_clock(sclk), .serial_cfg_data(sdata), .user_startup_clock(uclk));
  // ==========================================================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // bounded wait on a design output; running out ends the run
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge hclk);
      k++;
    end
    if (s !== v) begin
      error_cnt++;
      test_done();
    end
  endtask
  // ==========================================================================
  // bus master: hold each phase until hready is seen high
  task automatic hold();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      test_done();
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hold();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hold();
    q = hrdata;
    chk(hresp, 1'b0);
  endtask
  // no data before the status line is released; a stuck line ends the run
  task automatic ready();
    host.wait_ready(ok);
    chk(ok, 1'b1);
    if (!ok) test_done();
  endtask
  // sync byte plus one payload byte, each noted for the monitor
  task automatic load(input logic [7:0] b);
    ready();
    exp_q.push_back(`PSC_SYNC_BYTE);
    host.send_byte(`PSC_SYNC_BYTE);
    exp_q.push_back(b);
    host.send_byte(b);
    @(posedge hclk);
  endtask
  // startup clock keeps running while status is low, in case init was cut
  task automatic rcfg();
    fork
      host.pulse_rcfg(2000);
      host.user_clocks(60);
    join_none
    wait_for(err_oe, 1'b1, 80);
    t0 = $time;
    chk({ld_oe, hiz}, 2'h3);
    wait_for(err_oe, 1'b0, 400);
    chk($time - t0 >= 1900, 1'b1);
  endtask
  // ==========================================================================
  // clock and byte monitor
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (mon_on && byte_vld === 1'b1) begin
      chk(cfg_byte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    {hresetn, hsel, hwrite, cein_n, other_pull} = 5'h00;
    {haddr, hwdata, htrans} = 66'h0;
    ce_on = 1'b1;
    mon_on = 1'b1;
    error_cnt = 0;
    total_checks = 0;
    void'($urandom(32'h3969));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, unmapped word, deselected device ignores the link
    bus(`PSC_ADDR_CTRL, 1'b0, 32'h0);
    chk(q, 32'h0);
    bus(`PSC_ADDR_LEN, 1'b0, 32'h0);
    chk(q, `PSC_LEN_RST);
    bus(32'h0000_0010, 1'b1, 32'hFFFF_FFFF);
    bus(32'h0000_0010, 1'b0, 32'h0);
    chk(q, 32'h0);
    cein_n <= 1'b1;
    ready();
    host.send_byte(`PSC_SYNC_BYTE);
    @(posedge hclk);
    bus(`PSC_ADDR_COUNT, 1'b0, 32'h0);
    chk(q, 32'h0);
    cein_n <= 1'b0;
    // internal oscillator, init-done on, link clock busy during init
    bus(`PSC_ADDR_CTRL, 1'b1, 32'h2);
    bus(`PSC_ADDR_LEN, 1'b1, 32'h10);
    load(8'($urandom));
    wait_for(ceo_n, 1'b0, 20);
    t0 = $time;
    bus(`PSC_ADDR_STATUS, 1'b0, 32'h0);
    chk(q, psc_pkg::st_init);
    chk({idone_oe, ld_oe}, 2'h2);
    chk(idone_wire, 1'b0);
    // a stray byte here would hit the empty queue in the monitor
    host.send_byte(8'h00);
    @(posedge hclk);
    bus(`PSC_ADDR_COUNT, 1'b0, 32'h0);
    chk(q, 32'h0);
    wait_for(idone_oe, 1'b0, 5000);
    chk(idone_wire, 1'b1);
    chk(($time - t0) >= 18000 && ($time - t0) <= 40000, 1'b1);
    chk(hiz, 1'b0);
    rcfg();
    // user startup clock: one edge short stays in init, a frozen edge is lost
    bus(`PSC_ADDR_CTRL, 1'b1, 32'h1);
    load(8'($urandom));
    repeat (3000) @(posedge hclk);
    bus(`PSC_ADDR_STATUS, 1'b0, 32'h0);
    chk(q, psc_pkg::st_init);
    chk(idone_oe, 1'b0);
    host.user_clocks(298);
    repeat (8) @(posedge hclk);
    chk(hiz, 1'b1);
    ce_on <= 1'b0;
    host.user_clocks(1);
    repeat (2) @(posedge hclk);
    ce_on <= 1'b1;
    repeat (8) @(posedge hclk);
    chk(hiz, 1'b1);
    host.user_clocks(1);
    wait_for(hiz, 1'b0, 20);
    bus(`PSC_ADDR_CTRL, 1'b1, 32'h19);
    wait_for(ceo_n, 1'b1, 10);
    rcfg();
    // bad sync byte with auto-restart; the monitor sleeps meanwhile
    bus(`PSC_ADDR_CTRL, 1'b1, 32'h4);
    mon_on <= 1'b0;
    ready();
    // bit 7 set can never match the sync byte
    host.send_byte(8'($urandom) | 8'h80);
    @(posedge hclk);
    wait_for(err_oe, 1'b1, 30);
    t0 = $time;
    bus(`PSC_ADDR_STATUS, 1'b0, 32'h0);
    chk(q, 32'h110);
    wait_for(err_oe, 1'b0, 4000);
    chk($time - t0 >= 39000, 1'b1);
    bus(`PSC_ADDR_STATUS, 1'b0, 32'h0);
    chk(q, 32'h102);
    bus(`PSC_ADDR_STATUS, 1'b1, 32'h100);
    bus(`PSC_ADDR_STATUS, 1'b0, 32'h0);
    chk(q, 32'h2);
    mon_on <= 1'b1;
    // another device pulls the shared line; no auto-restart this time
    bus(`PSC_ADDR_CTRL, 1'b1, 32'h0);
    other_pull <= 1'b1;
    repeat (6) @(posedge hclk);
    other_pull <= 1'b0;
    bus(`PSC_ADDR_STATUS, 1'b0, 32'h0);
    chk(q[4:0], 5'h10);
    repeat (4100) @(posedge hclk);
    chk(err_oe, 1'b1);
    chk(ld_wire, 1'b0);
    rcfg();
    load(8'($urandom));
    wait_for(hiz, 1'b0, 2500);
    chk(exp_q.size(), 32'h0);
    test_done();
  end
endmodule
